// File: rtl/nmcp_params.svh
// Constants for the narrow memory control pin block
`ifndef NMCP_PARAMS_SVH
`define NMCP_PARAMS_SVH
`define NMCP_EA_W 20
`define NMCP_STRAP_ENDIAN_BIT 19
`define NMCP_STRAP_BOOT_HI 18
`define NMCP_STRAP_BOOT_LO 17
`define NMCP_STRAP_CLK_HI 14
`define NMCP_STRAP_CLK_LO 13
`define NMCP_RST_ENDIAN 1'b1
`define NMCP_RST_BOOT 2'b10
`define NMCP_RST_CLK_SEL 2'b00
`define NMCP_FIFO_SPACE 2'h3
`define NMCP_CPU4_HALF 2
`define NMCP_CPU6_HALF 3
`define NMCP_DIV_BY1 2'h0
`define NMCP_DIV_BY2 2'h1
`define NMCP_DIV_BY4 2'h2
`endif

// File: rtl/nmcp_pkg.sv
// Types for the narrow memory control pin block
package nmcp_pkg;
  typedef enum logic [1:0] {
    NMCP_ST_IDLE = 2'b00,
    NMCP_ST_SETUP = 2'b01,
    NMCP_ST_STROBE = 2'b10,
    NMCP_ST_HOLD = 2'b11
  } nmcp_state_t;
  typedef enum logic [1:0] {
    NMCP_MEM_ASYNC = 2'b00,
    NMCP_MEM_SDRAM = 2'b01,
    NMCP_MEM_SYNC = 2'b10,
    NMCP_MEM_NONE = 2'b11
  } nmcp_mem_t;
  typedef enum logic [1:0] {
    NMCP_CLK_EXT = 2'b00,
    NMCP_CLK_CPU4 = 2'b01,
    NMCP_CLK_CPU6 = 2'b10,
    NMCP_CLK_RSVD = 2'b11
  } nmcp_clk_src_t;
  typedef struct packed {
    logic rd_n;
    logic oe_n;
    logic we_n;
    logic fifo_oe_n;
  } nmcp_strobe_t;
  typedef struct packed {
    logic write;
    logic [1:0] space;
    logic [19:0] addr;
  } nmcp_req_t;
endpackage : nmcp_pkg

// File: rtl/nmcp_clksrc.sv
// Interface input clock source selection and core clock dividers
`timescale 1ns/1ps
`include "nmcp_params.svh"
module nmcp_clksrc
  import nmcp_pkg::*;
#(
  parameter int HALF4 = `NMCP_CPU4_HALF,
  parameter int HALF6 = `NMCP_CPU6_HALF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input nmcp_clk_src_t sel_i,
  input wire logic ext_lvl_i,
  output logic lvl_o
);
  // Three-bit half-period counter bounds what the divider can serve
  if (HALF4 < 1 || HALF4 > 7 || HALF6 < 1 || HALF6 > 7) begin : g_bad_half
    $error("nmcp_clksrc: half periods must lie in 1..7");
  end
  logic [2:0] cnt_r;
  logic phase_r;
  logic [2:0] half_last;
  assign half_last = (sel_i == NMCP_CLK_CPU6) ? 3'(HALF6 - 1) : 3'(HALF4 - 1);
  // Core clock divided by four or six as a square wave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
      phase_r <= 1'b0;
    end else if (ce_i) begin
      if (cnt_r >= half_last) begin
        cnt_r <= 3'h0;
        phase_r <= ~phase_r;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end
  // Reserved code falls back to the external pin, the safe default
  assign lvl_o = (sel_i == NMCP_CLK_CPU4 || sel_i == NMCP_CLK_CPU6) ? phase_r : ext_lvl_i;
endmodule : nmcp_clksrc

// File: rtl/nmcp_top.sv
// Narrow external memory control pins: strobes, clocks and reset straps
//
// Functional notes
// - Interface input clock chosen at reset from pin, core/4 or core/6 via straps.
// - External input clock pin is the default source.
// - Clock strap: 00 pin, 01 core/4, 10 core/6, 11 reserved.
// - Divided output clock is selected input clock over 1, 2 or 4.
// - Full-rate output clock runs at the selected input clock frequency.
// - Shared pin: async read, SDRAM column strobe or sync strobe by space type.
// - Sync spaces: select bit 0 gives address strobe, 1 gives read enable.
// - Second pin: async output enable, SDRAM row strobe or sync output enable.
// - Third pin: async, SDRAM or sync write enable by space type.
// - Dedicated sync output enable serves only chip-select space 3.
// - Ready input is sampled during async accesses; access waits while low.
// - Address pins carry half-word addresses, released when not driven.
// - During reset address pins are inputs and mode straps are read.
// - Endian strap: 0 big endian, 1 little endian, little is default.
// - Boot strap: 00 none, 01 host port, 10 8-bit ROM, 11 reserved.
// - At most one space enable asserted during any access.
`timescale 1ns/1ps
`include "nmcp_params.svh"
module nmcp_top
  import nmcp_pkg::*;
#(
  parameter int EA_W = `NMCP_EA_W
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic EXT_INPUT_CLOCK_I,
  input wire logic ASYNC_READY_IN_I,
  input wire logic [7:0] SPACE_TYPE_I,
  input wire logic [3:0] READ_STROBE_SELECT_I,
  input wire logic [1:0] DIV_SEL_I,
  input wire logic REQ_VALID_I,
  input nmcp_req_t REQ_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  input wire logic [EA_W-1:0] EXT_ADDRESS_BUS_I,
  output logic [EA_W-1:0] EXT_ADDRESS_BUS_O,
  output logic EXT_ADDRESS_BUS_OE_O,
  output logic [3:0] SPACE_SELECT_N_O,
  output logic SHARED_READ_STROBE_N_O,
  output logic SHARED_OUTPUT_STROBE_N_O,
  output logic SHARED_WRITE_STROBE_N_O,
  output logic FIFO_SPACE_OUTPUT_STROBE_N_O,
  output logic FULL_RATE_OUTPUT_CLOCK_O,
  output logic DIVIDED_OUTPUT_CLOCK_O,
  output logic ENDIAN_LITTLE_O,
  output logic [1:0] BOOT_MODE_O,
  output logic [1:0] INPUT_CLOCK_STRAP_O
);
  if (EA_W != `NMCP_EA_W) begin : g_bad_width
    $error("nmcp_top: strap positions assume a 20-bit address bus");
  end

  function automatic logic [3:0] space_decode(input logic [1:0] sp);
    space_decode = ~(4'h1 << sp);
  endfunction : space_decode

  function automatic nmcp_strobe_t strobe_decode(input nmcp_state_t st, input nmcp_mem_t mt,
                                                 input logic wr, input logic rsel, input logic [1:0] sp);
    nmcp_strobe_t s;
    s = '{rd_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, fifo_oe_n: 1'b1};
    case (mt)
      NMCP_MEM_ASYNC: begin
        if (st == NMCP_ST_STROBE) begin
          s.rd_n = wr;
          s.oe_n = wr;
          s.we_n = ~wr;
        end
      end
      NMCP_MEM_SDRAM: begin
        if (st == NMCP_ST_SETUP) begin
          s.oe_n = 1'b0;
        end
        if (st == NMCP_ST_STROBE) begin
          s.rd_n = 1'b0;
          s.we_n = ~wr;
        end
      end
      NMCP_MEM_SYNC: begin
        if (st == NMCP_ST_STROBE) begin
          s.rd_n = rsel ? wr : 1'b0;
          s.oe_n = wr;
          s.we_n = ~wr;
          s.fifo_oe_n = wr | (sp != `NMCP_FIFO_SPACE);
        end
      end
      default: begin
        s.rd_n = 1'b1;
      end
    endcase
    strobe_decode = s;
  endfunction : strobe_decode

  // Pin synchronisers; first stage read only by the second
  logic ext_clk_m_r, ext_clk_s_r, rdy_m_r, rdy_s_r;
  logic [EA_W-1:0] ea_m_r, ea_s_r;
  always_ff @(posedge MCLK_I) begin
    if (CE_I) begin
      ext_clk_m_r <= EXT_INPUT_CLOCK_I;
      ext_clk_s_r <= ext_clk_m_r;
      rdy_m_r <= ASYNC_READY_IN_I;
      rdy_s_r <= rdy_m_r;
      ea_m_r <= EXT_ADDRESS_BUS_I;
      ea_s_r <= ea_m_r;
    end
  end

  // Straps taken in the first enabled cycle after release
  logic armed_r;
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      armed_r <= 1'b1;
      ENDIAN_LITTLE_O <= `NMCP_RST_ENDIAN;
      BOOT_MODE_O <= `NMCP_RST_BOOT;
      INPUT_CLOCK_STRAP_O <= `NMCP_RST_CLK_SEL;
    end else if (CE_I && armed_r) begin
      armed_r <= 1'b0;
      ENDIAN_LITTLE_O <= ea_s_r[`NMCP_STRAP_ENDIAN_BIT];
      BOOT_MODE_O <= ea_s_r[`NMCP_STRAP_BOOT_HI:`NMCP_STRAP_BOOT_LO];
      INPUT_CLOCK_STRAP_O <= ea_s_r[`NMCP_STRAP_CLK_HI:`NMCP_STRAP_CLK_LO];
    end
  end

  logic iclk_lvl, iclk_prev_r, iclk_rise;
  nmcp_clksrc #(.HALF4(`NMCP_CPU4_HALF), .HALF6(`NMCP_CPU6_HALF)) u_clksrc (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .sel_i(nmcp_clk_src_t'(INPUT_CLOCK_STRAP_O)),
    .ext_lvl_i(ext_clk_s_r),
    .lvl_o(iclk_lvl)
  );
  assign iclk_rise = iclk_lvl & ~iclk_prev_r;

  // Output clocks; divider counts input clock rising edges
  logic [1:0] div_cnt_r;
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      // Seeded from the live level so release gives no false edge
      iclk_prev_r <= iclk_lvl;
      div_cnt_r <= 2'h0;
      FULL_RATE_OUTPUT_CLOCK_O <= 1'b0;
      DIVIDED_OUTPUT_CLOCK_O <= 1'b0;
    end else if (CE_I) begin
      iclk_prev_r <= iclk_lvl;
      if (iclk_rise) begin
        div_cnt_r <= div_cnt_r + 2'h1;
      end
      FULL_RATE_OUTPUT_CLOCK_O <= iclk_lvl;
      case (DIV_SEL_I)
        `NMCP_DIV_BY2: DIVIDED_OUTPUT_CLOCK_O <= div_cnt_r[0];
        `NMCP_DIV_BY4: DIVIDED_OUTPUT_CLOCK_O <= div_cnt_r[1];
        default: DIVIDED_OUTPUT_CLOCK_O <= iclk_lvl;
      endcase
    end
  end

  // Access sequencer, stepped by input clock rising edges
  nmcp_state_t state_r;
  nmcp_req_t req_r;
  nmcp_mem_t mt;
  assign mt = nmcp_mem_t'(SPACE_TYPE_I[2*req_r.space +: 2]);
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_r <= NMCP_ST_IDLE;
      req_r <= '0;
      DONE_O <= 1'b0;
    end else if (CE_I) begin
      DONE_O <= 1'b0;
      if (iclk_rise) begin
        case (state_r)
          NMCP_ST_IDLE: begin
            if (REQ_VALID_I && !armed_r) begin
              req_r <= REQ_I;
              state_r <= NMCP_ST_SETUP;
            end
          end
          NMCP_ST_SETUP: state_r <= NMCP_ST_STROBE;
          NMCP_ST_STROBE: begin
            // Slow async devices stretch the strobe by holding ready low
            if (mt != NMCP_MEM_ASYNC || rdy_s_r) begin
              state_r <= NMCP_ST_HOLD;
            end
          end
          NMCP_ST_HOLD: begin
            state_r <= NMCP_ST_IDLE;
            DONE_O <= 1'b1;
          end
          default: state_r <= NMCP_ST_IDLE;
        endcase
      end
    end
  end

  // Pin drivers, registered from the sequencer state
  nmcp_strobe_t stb;
  assign stb = strobe_decode(state_r, mt, req_r.write, READ_STROBE_SELECT_I[req_r.space], req_r.space);
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      EXT_ADDRESS_BUS_OE_O <= 1'b0;
      EXT_ADDRESS_BUS_O <= '0;
      SPACE_SELECT_N_O <= 4'hf;
      SHARED_READ_STROBE_N_O <= 1'b1;
      SHARED_OUTPUT_STROBE_N_O <= 1'b1;
      SHARED_WRITE_STROBE_N_O <= 1'b1;
      FIFO_SPACE_OUTPUT_STROBE_N_O <= 1'b1;
      REQ_READY_O <= 1'b0;
    end else if (CE_I) begin
      REQ_READY_O <= (state_r == NMCP_ST_IDLE) && !armed_r;
      EXT_ADDRESS_BUS_OE_O <= (state_r != NMCP_ST_IDLE);
      EXT_ADDRESS_BUS_O <= req_r.addr;
      SPACE_SELECT_N_O <= (state_r != NMCP_ST_IDLE) ? space_decode(req_r.space) : 4'hf;
      SHARED_READ_STROBE_N_O <= stb.rd_n;
      SHARED_OUTPUT_STROBE_N_O <= stb.oe_n;
      SHARED_WRITE_STROBE_N_O <= stb.we_n;
      FIFO_SPACE_OUTPUT_STROBE_N_O <= stb.fifo_oe_n;
    end
  end

  sequence s_release;
    RESET_I ##1 !RESET_I && CE_I;
  endsequence
  sequence s_async_wait;
    state_r == NMCP_ST_STROBE && mt == NMCP_MEM_ASYNC && !rdy_s_r && CE_I;
  endsequence

  property p_cs_onehot;
    @(posedge MCLK_I) disable iff (RESET_I) $onehot0(~SPACE_SELECT_N_O);
  endproperty
  a_cs_onehot: assert property (p_cs_onehot) else $error("more than one space enable");
  property p_strap_capture;
    @(posedge MCLK_I) s_release |=> !armed_r && ENDIAN_LITTLE_O == $past(ea_s_r[`NMCP_STRAP_ENDIAN_BIT]);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("endian strap not captured");
  property p_strap_hold;
    @(posedge MCLK_I) disable iff (RESET_I) !$past(armed_r) |-> $stable(BOOT_MODE_O) && $stable(INPUT_CLOCK_STRAP_O);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");
  property p_reset_release;
    @(posedge MCLK_I) RESET_I |=> !EXT_ADDRESS_BUS_OE_O && SPACE_SELECT_N_O == 4'hf;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("address driven in reset");
  property p_addr_released;
    @(posedge MCLK_I) disable iff (RESET_I) !EXT_ADDRESS_BUS_OE_O |-> SPACE_SELECT_N_O == 4'hf;
  endproperty
  a_addr_released: assert property (p_addr_released) else $error("space enabled without address");
  property p_async_wait;
    @(posedge MCLK_I) disable iff (RESET_I) s_async_wait |=> state_r == NMCP_ST_STROBE;
  endproperty
  a_async_wait: assert property (p_async_wait) else $error("async strobe ended without ready");
  property p_full_rate;
    @(posedge MCLK_I) disable iff (RESET_I) CE_I |=> FULL_RATE_OUTPUT_CLOCK_O == $past(iclk_lvl);
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate clock wrong");
  property p_div_one;
    @(posedge MCLK_I) disable iff (RESET_I)
      CE_I && DIV_SEL_I == `NMCP_DIV_BY1 |=> DIVIDED_OUTPUT_CLOCK_O == $past(iclk_lvl);
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one wrong");
  property p_fifo_space;
    @(posedge MCLK_I) disable iff (RESET_I) !FIFO_SPACE_OUTPUT_STROBE_N_O |-> !SPACE_SELECT_N_O[3];
  endproperty
  a_fifo_space: assert property (p_fifo_space) else $error("fifo strobe outside space 3");
  property p_ext_default;
    @(posedge MCLK_I) disable iff (RESET_I)
      INPUT_CLOCK_STRAP_O == `NMCP_RST_CLK_SEL && CE_I |=> FULL_RATE_OUTPUT_CLOCK_O == $past(ext_clk_s_r);
  endproperty
  a_ext_default: assert property (p_ext_default) else $error("external clock not selected");
endmodule : nmcp_top

// File: bench/nmcp_ext_mem_model.sv
// External side model: strap resistors, ready pin and input clock
`timescale 1ns/1ps
module nmcp_ext_mem_model (
  input wire logic clk_i,
  input wire logic [19:0] strap_i,
  input wire logic [7:0] wait_i,
  input wire logic [19:0] addr_i,
  input wire logic addr_oe_i,
  input wire logic rd_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [19:0] addr_o,
  output logic ready_o,
  output logic ext_clk_o
);
  logic [7:0] cnt_r;
  logic strobe;
  // Free running pin clock, offset so its edges never meet the core clock
  initial begin
    ext_clk_o = 1'b0;
    #3;
    forever #40 ext_clk_o = ~ext_clk_o;
  end
  // Released pins fall back to the fitted pull resistors
  assign addr_o = addr_oe_i ? addr_i : strap_i;
  assign strobe = !(rd_n_i && oe_n_i && we_n_i);
  always_ff @(posedge clk_i) begin
    if (!strobe) cnt_r <= 8'h00;
    else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
  end
  // Slow device holds ready low for wait_i cycles of each strobe
  assign ready_o = !(strobe && cnt_r < wait_i);
endmodule : nmcp_ext_mem_model

// File: bench/nmcp_top_tb_top.sv
// Testbench for the narrow memory control pin block
`timescale 1ns/1ps
module nmcp_top_tb_top import nmcp_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, ce = 1'b1;
  logic [7:0] sp_type = 8'ha4, wt = 8'h00;
  logic [3:0] rsel = 4'h8;
  logic [1:0] div = 2'h0;
  nmcp_req_t req = '0;
  logic [19:0] strap = 20'h00000;
  logic ext_clk, ready, req_rdy, done, addr_oe, rd_n, oe_n, we_n, fifo_n, fclk, dclk, endian;
  logic [1:0] boot, cks;
  logic [3:0] sel_n;
  logic [19:0] pin_in, addr_out;
  int n_fail = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  nmcp_top u_nmcp_top (
    .MCLK_I(clk), .RESET_I(rst), .CE_I(ce), .EXT_INPUT_CLOCK_I(ext_clk), .ASYNC_READY_IN_I(ready),
    .SPACE_TYPE_I(sp_type), .READ_STROBE_SELECT_I(rsel), .DIV_SEL_I(div), .REQ_VALID_I(vld), .REQ_I(req),
    .REQ_READY_O(req_rdy), .DONE_O(done), .EXT_ADDRESS_BUS_I(pin_in), .EXT_ADDRESS_BUS_O(addr_out),
    .EXT_ADDRESS_BUS_OE_O(addr_oe), .SPACE_SELECT_N_O(sel_n), .SHARED_READ_STROBE_N_O(rd_n),
    .SHARED_OUTPUT_STROBE_N_O(oe_n), .SHARED_WRITE_STROBE_N_O(we_n), .FIFO_SPACE_OUTPUT_STROBE_N_O(fifo_n),
    .FULL_RATE_OUTPUT_CLOCK_O(fclk), .DIVIDED_OUTPUT_CLOCK_O(dclk), .ENDIAN_LITTLE_O(endian),
    .BOOT_MODE_O(boot), .INPUT_CLOCK_STRAP_O(cks));

  nmcp_ext_mem_model u_nmcp_ext_mem_model (
    .clk_i(clk), .strap_i(strap), .wait_i(wt), .addr_i(addr_out), .addr_oe_i(addr_oe), .rd_n_i(rd_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_o(pin_in), .ready_o(ready), .ext_clk_o(ext_clk));

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic hang;
    n_fail++;
    $display("Wait ran out at %0t", $time);
    final_report();
  endtask : hang

  task automatic do_reset(input logic [1:0] s);
    int i;
    @(negedge clk);
    rst = 1'b1;
    strap = {s[0], s, 2'b00, s, 13'h0000};
    repeat (12) @(negedge clk);
    chk({endian, boot, cks}, 5'h18);
    rst = 1'b0;
    for (i = 0; i < 100 && req_rdy !== 1'b1; i++) @(negedge clk);
    if (req_rdy !== 1'b1) hang();
    chk({endian, boot, cks}, {s[0], s, s});
  endtask : do_reset

  task automatic period(input bit which, output int n);
    logic p;
    int i, r;
    r = 0;
    n = 0;
    for (i = 0; i < 400 && r < 2; i++) begin
      p = which ? dclk : fclk;
      @(negedge clk);
      if (r == 1) n++;
      if (p === 1'b0 && (which ? dclk : fclk) === 1'b1) r++;
    end
    if (r < 2) hang();
  endtask : period

  task automatic test_clocks;
    int exp_p[4] = '{8, 4, 6, 8};
    int n, s, d;
    // Reserved strap first, pin clock last so accesses run on it
    for (s = 3; s >= 0; s--) begin
      do_reset(s[1:0]);
      period(1'b0, n);
      chk(n, exp_p[s]);
    end
    // Code 11 runs undivided
    for (d = 0; d < 4; d++) begin
      div = d[1:0];
      repeat (80) @(negedge clk);
      period(1'b1, n);
      chk(n, (d == 3) ? 8 : (8 << d));
    end
    $display("test_clocks done");
  endtask : test_clocks

  task automatic test_freeze;
    logic [7:0] snap;
    @(negedge clk);
    ce = 1'b0;
    snap = {fclk, dclk, req_rdy, endian, boot, cks};
    repeat (20) @(negedge clk);
    chk({fclk, dclk, req_rdy, endian, boot, cks}, snap);
    ce = 1'b1;
    $display("test_freeze done");
  endtask : test_freeze

  task automatic access(input logic wr, input logic [1:0] sp, input logic [3:0] exp_low, output int n);
    logic [3:0] low;
    logic [19:0] a;
    int i;
    low = 4'h0;
    a = {17'h1a5c3, wr, sp};
    n = 0;
    @(negedge clk);
    req = '{write: wr, space: sp, addr: a};
    vld = 1'b1;
    for (i = 0; i < 400 && done !== 1'b1; i++) begin
      @(negedge clk);
      n++;
      low = low | ~{rd_n, oe_n, we_n, fifo_n};
      if (addr_oe === 1'b1) begin
        chk(addr_out, a);
        chk(sel_n, 4'(~(4'h1 << sp)));
      end
    end
    if (done !== 1'b1) hang();
    vld = 1'b0;
    chk(low, exp_low);
    @(negedge clk);
    chk({addr_oe, sel_n}, 5'h0f);
  endtask : access

  task automatic test_access;
    logic [3:0] e[8] = '{4'hc, 4'h2, 4'hc, 4'he, 4'hd, 4'h2, 4'hc, 4'ha};
    logic [1:0] sp[8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h2};
    int i, n, nf;
    // Space 0 async, 1 SDRAM, 2 sync address strobe, 3 sync read enable
    for (i = 0; i < 8; i++) begin
      access(i[0], sp[i], e[i], n);
      if (i == 0) nf = n;
    end
    wt = 8'd30;
    access(1'b0, 2'h0, 4'hc, n);
    wt = 8'd0;
    chk(n > nf + 20, 1);
    // Unused space type: select only, no strobes
    sp_type = 8'he4;
    access(1'b0, 2'h3, 4'h0, n);
    sp_type = 8'ha4;
    chk({endian, boot, cks}, 5'h00);
    $display("test_access done");
  endtask : test_access

  initial begin
    test_clocks();
    test_freeze();
    test_access();
    final_report();
  end
endmodule : nmcp_top_tb_top
